// File: core/fp_regs_consts.svh
`ifndef FP_REGS_CONSTS_SVH
`define FP_REGS_CONSTS_SVH

// ****************************************
// register indices
// ****************************************
`define IDX_FP_CTRL_TWO      8'h33
`define IDX_PANEL_UNLOCK     8'h34
`define IDX_MAP_UNLOCK       8'h35
`define IDX_MAP_INDEX        8'h38
`define IDX_MAP_DATA         8'h39
`define IDX_MAP_PD_CTRL      8'h3a
`define IDX_PANEL_HEIGHT     8'h3b
`define IDX_BLINK            8'h3c
`define IDX_REFRESH_PERIOD   8'h3f

// ****************************************
// reset values and keys
// ****************************************
`define RST_PANEL_UNLOCK     8'ha6
`define RST_MAP_PD_CTRL      8'h11
`define RST_ZERO             8'h00
`define PANEL_KEY            3'b101
`define SHADOW_KEY           3'b110
`define MAP_KEY              3'b011
`define PD_READ_MASK         8'h3f

// ****************************************
// field positions
// ****************************************
`define RD_REL_LO            6
`define WR_REL_LO            4
`define CGA_GRAY_BIT         3
`define SHADE_BIT            2
`define REF_NUM_BIT          1
`define REF_CTRL_BIT         0
`define PD_SEL_BIT           7
`define PD_INTCLK_BIT        6
`define HOST_REL_BIT         5
`define GRAY64_BIT           3
`define CBR_BIT              2
`define WEIGHT_BIT           1
`define GEN_PD_BIT           7
`define SCLK_EDGE_BIT        6
`define LP_CONT_BIT          7

// ****************************************
// timing counts
// ****************************************
`define REFRESH_MULT         11'd8
`define REFRESH_OFFSET       11'd5
`define BLINK_BASE           8'd8

`endif

// File: core/fp_regs_pkg.sv
package fp_regs_pkg;
    typedef enum logic [4:0] {
        PD_NONE    = 5'b00001,
        PD_SLEEP   = 5'b00010,
        PD_IDLE    = 5'b00100,
        PD_GEN_INT = 5'b01000,
        PD_GEN_EXT = 5'b10000
    } pd_mode_e;
    typedef enum logic [2:0] {
        CYC_IDLE  = 3'b001,
        CYC_ARB   = 3'b010,
        CYC_COUNT = 3'b100
    } cyc_state_e;
    typedef logic [7:0] byte_t;
endpackage

// File: core/flat_panel_control_regs.sv
// Notes on behaviour
// - read ready released after 1-4 clocks
// - write ready per code, from arbitration
// - bit 3 enables 16-level CGA gray
// - bit 2 picks FRM or PWM shading
// - refresh by CRTC or 1/2 per line
// - panel regs open while key 101
// - shadow open on 110; reset opens panel and shadow
// - mapping regs open while key 011
// - data port access bumps address counter
// - bit 7 idle or sleep, sleep stops clocks
// - bit 6 internal div-8 for general
// - host release ignores cycles, tristates bus
// - power-down keeps memory except sleep, outputs off
// - gray 64/32 and weighting switch
// - bits 5:0 readable only when unlocked
// - sleep gates clocks, external CBR refresh
// - idle divides clocks, refuses memory
// - general internal divides, timed refresh
// - general external keeps clocks, timed refresh
// - blink periods 8..128 frames, panels only
// - shift clock edge and line pulse
// - refresh period 8*(Z+5) video clocks
`include "fp_regs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module flat_panel_control_regs
    import fp_regs_pkg::*;
#(
    parameter int MAP_DEPTH = 256
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        io_index_wr,
    input  wire logic        io_data_wr,
    input  wire logic        io_data_rd,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    input  wire logic        mem_start,
    input  wire logic        mem_write,
    input  wire logic        arb_won,
    output logic             mem_ready,
    output logic             mem_refused,
    output logic             io_refused,
    output logic             sys_bus_oe,
    input  wire logic        power_down_input,
    input  wire logic        ext_refresh,
    input  wire logic        video_clock_tick,
    input  wire logic        crt_mode,
    output logic             refresh_req,
    output logic             refresh_cbr,
    output logic             refresh_by_crtc,
    output logic             refresh_two_per_line,
    output logic             clk_stop,
    output logic             clk_div8,
    output logic             ramdac_off,
    output logic             panel_off,
    output logic             cga_gray16,
    output logic             shading_pwm,
    output logic             gray64,
    output logic             weighting_en,
    output logic             shadow_unlocked,
    output logic [7:0]       panel_height_out,
    output logic [7:0]       cursor_blink_frames,
    output logic [7:0]       char_blink_frames,
    output logic             sclk_rising,
    output logic             lp_continuous,
    output logic [4:0]       pd_mode
);

    // ****************************************
    // registers and pin synchronisers
    // ****************************************
    byte_t fp_ctrl_two, panel_unlock, map_unlock, map_index;
    byte_t map_pd_ctrl, panel_height, blink_ctrl, refresh_period;
    byte_t host_index;
    byte_t map_ram [MAP_DEPTH];
    logic [MAP_DEPTH-1:0] map_valid;
    logic [1:0] pd_sync, ref_sync;
    logic       ref_last;
    pd_mode_e   mode;
    cyc_state_e cyc_state;
    logic       cyc_wr;
    logic [1:0] cyc_cnt;
    logic [10:0] ref_cnt;

    logic pd_low, panel_open, map_open, host_hold;
    logic io_ok, mem_ok, ext_edge;
    logic [10:0] ref_limit;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pd_sync  <= 2'b11;
            ref_sync <= 2'b00;
            ref_last <= 1'b0;
        end else if (ce) begin
            pd_sync  <= {pd_sync[0], power_down_input};
            ref_sync <= {ref_sync[0], ext_refresh};
            ref_last <= ref_sync[1];
        end
    end

    assign pd_low     = !pd_sync[1];
    assign ext_edge   = ref_sync[1] && !ref_last;
    assign panel_open = panel_unlock[7:5] == `PANEL_KEY;
    assign map_open   = map_unlock[6:4] == `MAP_KEY;
    assign host_hold  = map_pd_ctrl[`HOST_REL_BIT] && pd_low;
    // sleep and host release refuse everything, idle only memory
    assign io_ok      = !host_hold && mode != PD_SLEEP;
    assign mem_ok     = io_ok && mode != PD_IDLE;

    // ****************************************
    // access decode
    // ****************************************
    function automatic logic allowed(input byte_t idx, input logic p_open,
                                     input logic m_open);
        case (idx)
            `IDX_FP_CTRL_TWO, `IDX_MAP_UNLOCK, `IDX_PANEL_HEIGHT,
            `IDX_BLINK, `IDX_REFRESH_PERIOD: allowed = p_open;
            `IDX_MAP_INDEX, `IDX_MAP_DATA, `IDX_MAP_PD_CTRL: allowed = m_open;
            default: allowed = 1'b1;
        endcase
    endfunction

    logic wr_ok, rd_ok, data_touch;
    assign wr_ok = io_data_wr && io_ok && allowed(host_index, panel_open, map_open);
    assign rd_ok = io_data_rd && io_ok && allowed(host_index, panel_open, map_open);
    assign data_touch = (wr_ok || rd_ok) && host_index == `IDX_MAP_DATA;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            host_index <= `RST_ZERO;
        end else if (ce && io_index_wr && io_ok) begin
            host_index <= io_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fp_ctrl_two    <= `RST_ZERO;
            panel_unlock   <= `RST_PANEL_UNLOCK;
            map_unlock     <= `RST_ZERO;
            map_pd_ctrl    <= `RST_MAP_PD_CTRL;
            panel_height   <= `RST_ZERO;
            blink_ctrl     <= `RST_ZERO;
            refresh_period <= `RST_ZERO;
        end else if (ce && wr_ok) begin
            case (host_index)
                `IDX_FP_CTRL_TWO:    fp_ctrl_two <= io_wdata;
                `IDX_PANEL_UNLOCK:   panel_unlock <= io_wdata;
                `IDX_MAP_UNLOCK:     map_unlock <= io_wdata;
                `IDX_MAP_PD_CTRL:    map_pd_ctrl <= io_wdata;
                `IDX_PANEL_HEIGHT:   panel_height <= io_wdata;
                `IDX_BLINK:          blink_ctrl <= io_wdata;
                `IDX_REFRESH_PERIOD: refresh_period <= io_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // mapping ram and address counter
    // ****************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            map_index <= `RST_ZERO;
        end else if (ce) begin
            if (data_touch) begin
                map_index <= map_index + 8'h01;
            end else if (wr_ok && host_index == `IDX_MAP_INDEX) begin
                map_index <= io_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ce && wr_ok && host_index == `IDX_MAP_DATA) begin
            map_ram[map_index] <= io_wdata;
        end
    end

    // valid bits stand in for ram contents that sleep destroys
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            map_valid <= '0;
        end else if (ce) begin
            if (mode == PD_SLEEP) begin
                map_valid <= '0;
            end else if (wr_ok && host_index == `IDX_MAP_DATA) begin
                map_valid[map_index] <= 1'b1;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    byte_t next_rdata;
    always_comb begin
        next_rdata = `RST_ZERO;
        case (host_index)
            `IDX_FP_CTRL_TWO:    next_rdata = fp_ctrl_two;
            `IDX_PANEL_UNLOCK:   next_rdata = panel_unlock;
            `IDX_MAP_UNLOCK:     next_rdata = map_unlock;
            `IDX_MAP_INDEX:      next_rdata = map_index;
            `IDX_MAP_DATA:       next_rdata = map_valid[map_index] ?
                                              map_ram[map_index] : `RST_ZERO;
            `IDX_MAP_PD_CTRL:    next_rdata = map_pd_ctrl & `PD_READ_MASK;
            `IDX_PANEL_HEIGHT:   next_rdata = panel_height;
            `IDX_BLINK:          next_rdata = blink_ctrl;
            `IDX_REFRESH_PERIOD: next_rdata = refresh_period;
            default:             next_rdata = `RST_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= `RST_ZERO;
        end else if (ce && io_data_rd) begin
            io_rdata <= rd_ok ? next_rdata : `RST_ZERO;
        end
    end

    // ****************************************
    // power-down mode
    // ****************************************
    pd_mode_e next_mode;
    always_comb begin
        next_mode = PD_NONE;
        if (pd_low) begin
            if (refresh_period[`GEN_PD_BIT]) begin
                next_mode = map_pd_ctrl[`PD_INTCLK_BIT] ? PD_GEN_INT : PD_GEN_EXT;
            end else begin
                next_mode = map_pd_ctrl[`PD_SEL_BIT] ? PD_SLEEP : PD_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode <= PD_NONE;
        end else if (ce) begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clk_stop   <= 1'b0;
            clk_div8   <= 1'b0;
            ramdac_off <= 1'b0;
            panel_off  <= 1'b0;
        end else if (ce) begin
            clk_stop   <= next_mode == PD_SLEEP;
            clk_div8   <= next_mode == PD_IDLE || next_mode == PD_GEN_INT;
            ramdac_off <= next_mode != PD_NONE;
            panel_off  <= next_mode != PD_NONE;
        end
    end

    // ****************************************
    // refresh scheduling
    // ****************************************
    logic gen_mode;
    assign gen_mode  = mode == PD_GEN_INT || mode == PD_GEN_EXT;
    assign ref_limit = `REFRESH_MULT * ({4'h0, refresh_period[6:0]} + `REFRESH_OFFSET);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ref_cnt     <= 11'd0;
            refresh_req <= 1'b0;
        end else if (ce) begin
            refresh_req <= 1'b0;
            if (!gen_mode) begin
                ref_cnt     <= 11'd0;
                refresh_req <= (mode == PD_SLEEP || mode == PD_IDLE) && ext_edge;
            end else if (video_clock_tick) begin
                if (ref_cnt == ref_limit - 11'd1) begin
                    ref_cnt     <= 11'd0;
                    refresh_req <= 1'b1;
                end else begin
                    ref_cnt <= ref_cnt + 11'd1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            refresh_cbr          <= 1'b0;
            refresh_by_crtc      <= 1'b1;
            refresh_two_per_line <= 1'b0;
        end else if (ce) begin
            refresh_cbr <= (mode == PD_SLEEP || mode == PD_IDLE) ||
                           map_pd_ctrl[`CBR_BIT];
            refresh_by_crtc      <= !fp_ctrl_two[`REF_CTRL_BIT];
            refresh_two_per_line <= fp_ctrl_two[`REF_CTRL_BIT] &&
                                    fp_ctrl_two[`REF_NUM_BIT];
        end
    end

    // ****************************************
    // host memory cycle ready release
    // ****************************************
    logic [1:0] rd_code, wr_code, need_m1;
    assign rd_code = fp_ctrl_two[`RD_REL_LO+:2];
    assign wr_code = fp_ctrl_two[`WR_REL_LO+:2];
    // write code 00 ends one clock after arbitration, the same as read code 00
    assign need_m1 = cyc_wr ? ((wr_code == 2'b00) ? 2'b00 : wr_code) : rd_code;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_state <= CYC_IDLE;
            cyc_wr    <= 1'b0;
            cyc_cnt   <= 2'b00;
            mem_ready <= 1'b0;
        end else if (ce) begin
            mem_ready <= 1'b0;
            case (cyc_state)
                CYC_IDLE: begin
                    if (mem_start && mem_ok) begin
                        cyc_wr    <= mem_write;
                        cyc_state <= CYC_ARB;
                    end
                end
                CYC_ARB: begin
                    if (arb_won) begin
                        cyc_cnt <= need_m1;
                        if (need_m1 == 2'b00) begin
                            mem_ready <= 1'b1;
                            cyc_state <= CYC_IDLE;
                        end else begin
                            cyc_state <= CYC_COUNT;
                        end
                    end
                end
                CYC_COUNT: begin
                    cyc_cnt <= cyc_cnt - 2'b01;
                    if (cyc_cnt == 2'b01) begin
                        mem_ready <= 1'b1;
                        cyc_state <= CYC_IDLE;
                    end
                end
                default: cyc_state <= CYC_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_refused <= 1'b0;
            io_refused  <= 1'b0;
            sys_bus_oe  <= 1'b1;
        end else if (ce) begin
            mem_refused <= !mem_ok;
            io_refused  <= !io_ok;
            sys_bus_oe  <= !host_hold;
        end
    end

    // ****************************************
    // panel options and blink
    // ****************************************
    function automatic byte_t blink_frames(input logic [2:0] code, input logic crt);
        if (crt || code == 3'b000 || code > 3'b101) begin
            blink_frames = 8'h00;
        end else begin
            blink_frames = `BLINK_BASE << (code - 3'd1);
        end
    endfunction

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cga_gray16          <= 1'b0;
            shading_pwm         <= 1'b0;
            gray64              <= 1'b0;
            weighting_en        <= 1'b0;
            shadow_unlocked     <= 1'b1;
            panel_height_out    <= `RST_ZERO;
            cursor_blink_frames <= `RST_ZERO;
            char_blink_frames   <= `RST_ZERO;
            sclk_rising         <= 1'b0;
            lp_continuous       <= 1'b0;
        end else if (ce) begin
            cga_gray16          <= fp_ctrl_two[`CGA_GRAY_BIT];
            shading_pwm         <= fp_ctrl_two[`SHADE_BIT];
            gray64              <= map_pd_ctrl[`GRAY64_BIT];
            weighting_en        <= map_pd_ctrl[`WEIGHT_BIT];
            shadow_unlocked     <= panel_unlock[2:0] == `SHADOW_KEY;
            panel_height_out    <= panel_height;
            cursor_blink_frames <= blink_frames(blink_ctrl[2:0], crt_mode);
            char_blink_frames   <= blink_frames(blink_ctrl[5:3], crt_mode);
            sclk_rising         <= !crt_mode && blink_ctrl[`SCLK_EDGE_BIT];
            lp_continuous       <= !crt_mode && blink_ctrl[`LP_CONT_BIT];
        end
    end

    assign pd_mode = mode;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst || !ce);

    read_ready_4_a: assert property (cyc_state == CYC_ARB && arb_won && !cyc_wr &&
        rd_code == 2'b11 && ce |=> !mem_ready [*3] ##1 mem_ready)
        else $error("read ready not after four clocks");
    write_ready_00_a: assert property (cyc_state == CYC_ARB && arb_won && cyc_wr &&
        wr_code == 2'b00 |-> ##1 mem_ready)
        else $error("write code 00 ready late");
    write_ready_10_a: assert property (cyc_state == CYC_ARB && arb_won && cyc_wr &&
        wr_code == 2'b10 |-> ##2 !mem_ready ##1 mem_ready)
        else $error("write code 10 ready wrong");
    panel_lock_a: assert property (io_data_wr && !panel_open &&
        host_index == `IDX_PANEL_HEIGHT |=> $stable(panel_height))
        else $error("locked panel register written");
    map_lock_rd_a: assert property (io_data_rd && !map_open &&
        host_index == `IDX_MAP_INDEX |=> io_rdata == 8'h00)
        else $error("locked mapping register read");
    counter_step_a: assert property (data_touch |=> map_index == $past(map_index) + 8'h01)
        else $error("address counter did not step");
    pd_hidden_a: assert property (rd_ok && host_index == `IDX_MAP_PD_CTRL
        |=> io_rdata[7:6] == 2'b00)
        else $error("write-only power-down bits read back");
    host_hold_a: assert property (host_hold |=> !sys_bus_oe && io_refused)
        else $error("bus not released under host hold");
    sleep_clk_a: assert property (next_mode == PD_SLEEP |=> clk_stop && ramdac_off
        && panel_off && !clk_div8)
        else $error("sleep outputs wrong");
    idle_mem_a: assert property (mode == PD_IDLE && !host_hold |-> !mem_ok && io_ok)
        else $error("idle access gating wrong");
    refresh_period_a: assert property (refresh_req && gen_mode |->
        $past(ref_cnt) == ref_limit - 11'd1)
        else $error("refresh period wrong");
    blink_crt_a: assert property (crt_mode |=> cursor_blink_frames == 8'h00 &&
        char_blink_frames == 8'h00)
        else $error("blink active in crt mode");

    cover property (mem_ready && cyc_wr);
    cover property (refresh_req && mode == PD_GEN_INT);
    cover property (data_touch ##1 data_touch);
    cover property (mode == PD_SLEEP);

endmodule

`default_nettype wire

// File: verif/host_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host memory cycle model
// ****************************************
module host_mem_model (
    input  wire logic ref_clk,
    output logic      mem_start,
    output logic      mem_write,
    output logic      arb_won,
    input  wire logic mem_ready
);
    initial begin
        mem_start = 1'b0;
        mem_write = 1'b0;
        arb_won   = 1'b0;
    end
    // n counts falling edges after the arbitration edge, 16 means no ready
    task automatic mem_cycle(input logic wr, output int n);
        @(negedge ref_clk);
        mem_write = wr;
        mem_start = 1'b1;
        @(negedge ref_clk);
        mem_start = 1'b0;
        arb_won   = 1'b1;
        @(negedge ref_clk);
        arb_won = 1'b0;
        n = 1;
        while (mem_ready !== 1'b1 && n < 16) begin
            @(negedge ref_clk);
            n++;
        end
        // no kinder than a real host: the qualifier does not linger
        mem_write = ~wr;
    endtask
endmodule
`default_nettype wire

// File: verif/flat_panel_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_regs_consts.svh"
`define chk(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t got %h expected %h", $time, g, e); end end
// ****************************************
// bench
// ****************************************
module flat_panel_control_regs_bench;
    logic ref_clk, nrst, ce, io_index_wr, io_data_wr, io_data_rd;
    logic power_down_input, ext_refresh, video_clock_tick, crt_mode;
    logic [7:0] io_wdata, d;
    wire logic [7:0] io_rdata, panel_height_out, cursor_blink_frames, char_blink_frames;
    wire logic mem_start, mem_write, arb_won, mem_ready, mem_refused, io_refused;
    wire logic sys_bus_oe, refresh_by_crtc, refresh_two_per_line, clk_div8, ramdac_off;
    wire logic panel_off, cga_gray16, shading_pwm, gray64, shadow_unlocked, lp_continuous;
    wire logic [4:0] pd_mode;
    wire logic clk_stop, refresh_cbr, weighting_en, sclk_rising, refresh_req;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;
    flat_panel_control_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
        .io_index_wr(io_index_wr), .io_data_wr(io_data_wr), .io_data_rd(io_data_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_start(mem_start),
        .mem_write(mem_write), .arb_won(arb_won), .mem_ready(mem_ready),
        .mem_refused(mem_refused), .io_refused(io_refused), .sys_bus_oe(sys_bus_oe),
        .power_down_input(power_down_input), .ext_refresh(ext_refresh),
        .video_clock_tick(video_clock_tick), .crt_mode(crt_mode), .refresh_req(refresh_req),
        .refresh_cbr(refresh_cbr), .refresh_by_crtc(refresh_by_crtc),
        .refresh_two_per_line(refresh_two_per_line), .clk_stop(clk_stop), .clk_div8(clk_div8),
        .ramdac_off(ramdac_off), .panel_off(panel_off), .cga_gray16(cga_gray16),
        .shading_pwm(shading_pwm), .gray64(gray64), .weighting_en(weighting_en),
        .shadow_unlocked(shadow_unlocked), .panel_height_out(panel_height_out),
        .cursor_blink_frames(cursor_blink_frames), .char_blink_frames(char_blink_frames),
        .sclk_rising(sclk_rising), .lp_continuous(lp_continuous), .pd_mode(pd_mode));
    host_mem_model u_host (.ref_clk(ref_clk), .mem_start(mem_start),
        .mem_write(mem_write), .arb_won(arb_won), .mem_ready(mem_ready));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
        @(negedge ref_clk);
        io_index_wr = 1'b1;
        io_wdata = idx;
        @(negedge ref_clk);
        io_index_wr = 1'b0;
        io_data_wr = 1'b1;
        io_wdata = v;
        @(negedge ref_clk);
        io_data_wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] v);
        @(negedge ref_clk);
        io_index_wr = 1'b1;
        io_wdata = idx;
        @(negedge ref_clk);
        io_index_wr = 1'b0;
        io_data_rd = 1'b1;
        @(negedge ref_clk);
        io_data_rd = 1'b0;
        @(negedge ref_clk);
        v = io_rdata;
    endtask
    task automatic wrap_up();
        $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {nrst, io_index_wr, io_data_wr, io_data_rd, io_wdata} = '0;
        {ce, power_down_input, ext_refresh, video_clock_tick, crt_mode} = 5'b11000;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        rd_reg(`IDX_PANEL_UNLOCK, d);
        `chk(d, 8'ha6)
        `chk({shadow_unlocked, refresh_by_crtc}, 2'b11)
        wr_reg(`IDX_MAP_INDEX, 8'h12);
        rd_reg(`IDX_MAP_INDEX, d);
        `chk(d, 8'h00)
        wr_reg(`IDX_MAP_UNLOCK, 8'h30);
        wr_reg(`IDX_MAP_INDEX, 8'hff);
        wr_reg(`IDX_MAP_DATA, 8'haa);
        rd_reg(`IDX_MAP_INDEX, d);
        `chk(d, 8'h00)
        rd_reg(`IDX_MAP_PD_CTRL, d);
        `chk(d, 8'h11)
        wr_reg(`IDX_MAP_PD_CTRL, 8'h19);
        rd_reg(`IDX_MAP_PD_CTRL, d);
        `chk({d, gray64}, 9'h033)
        wr_reg(`IDX_PANEL_UNLOCK, 8'ha0);
        wr_reg(`IDX_FP_CTRL_TWO, 8'h0f);
        @(negedge ref_clk);
        `chk(shadow_unlocked, 1'b0)
        `chk({cga_gray16, shading_pwm}, 2'b11)
        `chk({refresh_by_crtc, refresh_two_per_line}, 2'b01)
        wr_reg(`IDX_PANEL_UNLOCK, 8'h00);
        wr_reg(`IDX_FP_CTRL_TWO, 8'h00);
        rd_reg(`IDX_FP_CTRL_TWO, d);
        `chk(d, 8'h00)
        wr_reg(`IDX_PANEL_UNLOCK, 8'ha6);
        rd_reg(`IDX_FP_CTRL_TWO, d);
        `chk(d, 8'h0f)
        for (int c = 0; c < 4; c++) begin
            wr_reg(`IDX_FP_CTRL_TWO, {c[1:0], c[1:0], 4'h0});
            u_host.mem_cycle(1'b0, n);
            `chk(n, c + 1)
            u_host.mem_cycle(1'b1, n);
            `chk(n, c + 1)
            if (n >= 16) wrap_up();
        end
        wr_reg(`IDX_BLINK, 8'hab);
        wr_reg(`IDX_PANEL_HEIGHT, 8'hef);
        @(negedge ref_clk);
        `chk({cursor_blink_frames, char_blink_frames}, 16'h2080)
        `chk({lp_continuous, sclk_rising, panel_height_out}, 10'h2ef)
        // clock enable low: the write must not land
        ce = 1'b0;
        wr_reg(`IDX_PANEL_HEIGHT, 8'h11);
        ce = 1'b1;
        rd_reg(`IDX_PANEL_HEIGHT, d);
        `chk(d, 8'hef)
        crt_mode = 1'b1;
        repeat (2) @(negedge ref_clk);
        `chk({cursor_blink_frames, char_blink_frames, lp_continuous}, 17'h00000)
        crt_mode = 1'b0;
        // idle mode: general power-down stays off
        power_down_input = 1'b0;
        repeat (4) @(negedge ref_clk);
        `chk(pd_mode, 5'b00100)
        `chk({mem_refused, io_refused, clk_div8}, 3'b101)
        `chk({ramdac_off, panel_off}, 2'b11)
        wr_reg(`IDX_MAP_PD_CTRL, 8'h39);
        @(negedge ref_clk);
        `chk({sys_bus_oe, io_refused}, 2'b01)
        power_down_input = 1'b1;
        repeat (4) @(negedge ref_clk);
        `chk({sys_bus_oe, pd_mode}, 6'h21)
        // sleep: clocks stop, access refused, mapping ram lost
        wr_reg(`IDX_MAP_PD_CTRL, 8'h91);
        power_down_input = 1'b0;
        repeat (4) @(negedge ref_clk);
        `chk({pd_mode, clk_stop, io_refused, mem_refused, refresh_cbr}, 9'h02f)
        power_down_input = 1'b1;
        repeat (4) @(negedge ref_clk);
        wr_reg(`IDX_MAP_INDEX, 8'hff);
        rd_reg(`IDX_MAP_DATA, d);
        `chk(d, 8'h00)
        rd_reg(`IDX_MAP_INDEX, d);
        `chk(d, 8'h00)
        // general power-down, internal clock, z = 0
        wr_reg(`IDX_REFRESH_PERIOD, 8'h80);
        wr_reg(`IDX_MAP_PD_CTRL, 8'h53);
        power_down_input = 1'b0;
        video_clock_tick = 1'b1;
        n = 0;
        while (refresh_req !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        `chk(refresh_req, 1'b1)
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (refresh_req !== 1'b1 && n < 200);
        `chk(n, 40)
        `chk({pd_mode, clk_div8, weighting_en, refresh_cbr, mem_refused}, 9'h08c)
        wr_reg(`IDX_MAP_PD_CTRL, 8'h13);
        @(negedge ref_clk);
        `chk({pd_mode, clk_div8, io_refused}, 7'h40)
        wrap_up();
    end
endmodule
`undef chk
`default_nettype wire
